// File: verif/rtd_clock_ctrl_tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module rtd_clock_ctrl_tb;
    logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, seqv;
    logic [3:0] wb_sel_i;
    rtd_pkg::rtd_cfg_t cfg;
    rtd_pkg::rtd_osc_out_t osc_out;
    logic [5:0] rollover_count;
    logic osc_fail_detect, osc_running, power_up_timer_expired, clock_fail_trap, low_power_rc_wdt_run;
    logic run, osc_start, osc_kill, pseudo_random_dither_m, prev3;
    logic [15:0] rnd, ta, tb_v;
    logic [14:0] lfsr_m;
    int err_count, num_checks, cyc_n;
    rtd_clock_ctrl rtd_clock_ctrl_i (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_dat_o, .wb_ack_o, .cfg, .rollover_count, .osc_fail_detect, .osc_running,
        .power_up_timer_expired, .osc_out, .clock_fail_trap, .low_power_rc_wdt_run);
    rtd_pwm_model rtd_pwm_model_i (.sys_clk, .rst_n, .run, .osc_start, .osc_kill, .rollover_count,
        .osc_running, .osc_fail_detect);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        wb_sel_i <= 4'h3;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1) @(posedge sys_clk);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 16'h0000, rd);
        chk(rd, e);
    endtask
    task automatic do_rst(input logic [5:0] c, input logic pw, input logic st);
        rst_n <= 1'b0;
        cfg <= c;
        power_up_timer_expired <= pw;
        osc_start <= st;
        osc_kill <= 1'b0;
        pseudo_random_dither_m = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask
    task automatic roll_to(input logic [2:0] k);
        run <= 1'b1;
        @(posedge sys_clk);
        while (rollover_count[5:3] !== k) @(posedge sys_clk);
        run <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic wait_trap();
        for (int i = 0; i < 30 && clock_fail_trap !== 1'b1; i++) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_m <= rtd_pkg::LFSR_SEED;
            prev3 <= 1'b0;
        end else begin
            if (pseudo_random_dither_m && rollover_count[3] !== prev3) begin
                lfsr_m <= {lfsr_m[13:0], lfsr_m[14] ^ lfsr_m[13]};
            end
            prev3 <= rollover_count[3];
        end
    end
    always @(posedge sys_clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        err_count = 0;
        num_checks = 0;
        cyc_n = 0;
        rnd = 16'h001C;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        run = 1'b0;
        do_rst(6'h00, 1'b0, 1'b0);
        wr(8'h0C, 16'hFFFF);
        wr(8'h10, 16'hFFFF);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h0C, {13'h0, rtd_pkg::LFSR_SEED, 4'h0});
        rdc(8'h10, 32'h0);
        $display("test 1 done");
        rnd = nxt(rnd);
        ta = rnd;
        rnd = nxt(rnd);
        tb_v = rnd;
        wr(8'h04, ta);
        wr(8'h08, tb_v);
        repeat (2) @(posedge sys_clk);
        chk(osc_out.frc_tune, ta[3:0]);
        wr(8'h00, 16'h0002);
        for (int k = 0; k < 8; k++) begin
            roll_to(k[2:0]);
            seqv = {tb_v, ta} >> (4 * k);
            chk(osc_out.frc_tune, seqv[3:0]);
            rdc(8'h0C, {13'h0, lfsr_m, seqv[3:0]});
        end
        $display("test 2 done");
        wr(8'h00, 16'h0004);
        pseudo_random_dither_m = 1'b1;
        run <= 1'b1;
        repeat (300) @(posedge sys_clk);
        run <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(osc_out.frc_tune, lfsr_m[3:0]);
        rdc(8'h0C, {13'h0, lfsr_m, lfsr_m[3:0]});
        wr(8'h00, 16'h0000);
        pseudo_random_dither_m = 1'b0;
        roll_to(3'h0);
        chk(osc_out.frc_tune, ta[3:0]);
        rdc(8'h0C, {13'h0, lfsr_m, ta[3:0]});
        $display("test 3 done");
        wr(8'h00, 16'h0101);
        repeat (10) @(posedge sys_clk);
        chk(osc_out.osc_select, rtd_pkg::OSC_FRC);
        osc_start <= 1'b1;
        for (int i = 0; i < 30 && osc_out.osc_select !== 3'h2; i++) @(posedge sys_clk);
        chk(osc_out.osc_select, 3'h2);
        rdc(8'h00, 32'h2100);
        wr(8'h00, 16'h0101);
        repeat (5) @(posedge sys_clk);
        rdc(8'h00, 32'h2100);
        $display("test 4 done");
        osc_kill <= 1'b1;
        wait_trap();
        chk(clock_fail_trap, 1'b1);
        repeat (2) @(posedge sys_clk);
        chk(osc_out.osc_select, rtd_pkg::OSC_FRC);
        rdc(8'h00, 32'h0108);
        chk(low_power_rc_wdt_run, 1'b1);
        wr(8'h00, 16'h0108);
        rdc(8'h00, 32'h0100);
        $display("test 5 done");
        do_rst(6'h08, 1'b1, 1'b0);
        wait_trap();
        chk(clock_fail_trap, 1'b1);
        repeat (2) @(posedge sys_clk);
        chk(osc_out.osc_select, rtd_pkg::OSC_FRC);
        rdc(8'h00, 32'h0008);
        $display("test 6 done");
        do_rst(6'h18, 1'b1, 1'b0);
        repeat (10) @(posedge sys_clk);
        chk(clock_fail_trap, 1'b0);
        chk(osc_out.osc_select, 3'h2);
        rdc(8'h00, 32'h2000);
        do_rst(6'h2D, 1'b1, 1'b0);
        osc_kill <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk(osc_out.osc_select, 3'h3);
        chk(osc_out.primary_mode, 2'h1);
        wr(8'h00, 16'h0001);
        rdc(8'h00, 32'h3000);
        $display("test 7 done");
        print_verdict();
    end
endmodule // rtd_clock_ctrl_tb

// File: verif/rtd_properties.sv
// Port timing checker for the clock control block
`timescale 1ns/1ps
module rtd_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire rtd_pkg::rtd_cfg_t cfg,
    input wire logic [5:0] rollover_count,
    input wire rtd_pkg::rtd_osc_out_t osc_out,
    input wire logic clock_fail_trap,
    input wire logic low_power_rc_wdt_run
);
    logic [5:0] roll_q;
    logic roll_chg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            roll_q <= 6'h00;
        end else begin
            roll_q <= rollover_count;
        end
    end
    assign roll_chg = rollover_count != roll_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_trap_pulse: assert property (clock_fail_trap |=> !clock_fail_trap)
        else $error("trap longer than one cycle");
    a_trap_to_frc: assert property (clock_fail_trap |-> osc_out.osc_select == rtd_pkg::OSC_FRC)
        else $error("trap without fast RC selected");
    a_cfg_mirror: assert property (cfg.switch_monitor_config[1] ##1 $stable(cfg) [*2] |->
        osc_out.osc_select == {1'b0, cfg.new_osc_group_config})
        else $error("select does not follow config");
    a_no_trap_off: assert property (cfg.switch_monitor_config[1] && $stable(cfg) |-> !clock_fail_trap)
        else $error("trap with monitor disabled");
    a_wdt_runs: assert property ($past(rst_n) |-> low_power_rc_wdt_run)
        else $error("watchdog clock stopped");
    a_tune_cause: assert property ($changed(osc_out.frc_tune) |->
        $past(wb_ack_o) || $past(roll_chg) || $past(roll_chg, 2))
        else $error("tune changed without cause");
endmodule // rtd_props

bind rtd_clock_ctrl rtd_props rtd_props_i (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cfg,
    .rollover_count, .osc_out, .clock_fail_trap, .low_power_rc_wdt_run);

// File: verif/rtd_pwm_model.sv
// PWM rollover counter and primary oscillator model
`timescale 1ns/1ps
module rtd_pwm_model #(
    parameter int PERIOD = 2,
    parameter int START_DLY = 5
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic osc_start,
    input wire logic osc_kill,
    output logic [5:0] rollover_count,
    output logic osc_running,
    output logic osc_fail_detect
);
    int tb_cnt;
    int st_cnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tb_cnt <= 0;
            rollover_count <= 6'h00;
        end else if (run) begin
            tb_cnt <= (tb_cnt == PERIOD - 1) ? 0 : tb_cnt + 1;
            if (tb_cnt == PERIOD - 1) begin
                rollover_count <= rollover_count + 6'h01;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n || !osc_start) begin
            st_cnt <= 0;
        end else if (st_cnt < START_DLY) begin
            st_cnt <= st_cnt + 1;
        end
    end
    assign osc_running = osc_start && st_cnt == START_DLY && !osc_kill;
    assign osc_fail_detect = osc_kill;
endmodule // rtd_pwm_model

// File: verilog/rtd_clock_ctrl.sv
// Tune dither, clock switch and fail-safe monitor with Wishbone registers
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module rtd_clock_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire rtd_pkg::rtd_cfg_t cfg,
    input wire logic [5:0] rollover_count,
    input wire logic osc_fail_detect,
    input wire logic osc_running,
    input wire logic power_up_timer_expired,
    output rtd_pkg::rtd_osc_out_t osc_out,
    output logic clock_fail_trap,
    output logic low_power_rc_wdt_run
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_SWAP = 3'b010,
        ST_FAIL_CURRENT_OSC_FIELD = 3'b011,
        ST_FAIL_FLAG = 3'b100,
        ST_FAIL_CLR = 3'b101
    } rtd_state_t;

    rtd_state_t state;
    rtd_state_t next_state;

    logic [15:0] tune_register_a;
    logic [15:0] tune_register_b;
    logic [2:0] current_osc_field;
    logic [2:0] target_osc;
    logic new_group_primary;
    logic clock_fail_flag;
    logic random_dither_enable;
    logic tune_sequence_enable;
    logic osc_switch_enable;
    logic init_done;
    logic roll3_prev;
    logic lfsr_step;
    logic [14:0] lfsr_state;
    logic [3:0] next_tune;
    logic [3:0] seq_field [rtd_pkg::SEQ_STEPS];
    logic [2:0] roll_sel;
    logic [2:0] direct_osc;
    logic [2:0] primary_osc;
    logic switch_allowed;
    logic monitor_on;
    logic fail_cause;
    logic [1:0] sync_out;
    logic osc_fail_s;
    logic osc_running_s;
    logic bus_req;
    logic bus_wr;
    logic [15:0] wmask;
    logic [31:0] next_rdata;
    logic [2:0] applied_osc;
    logic [1:0] applied_mode;
    logic [3:0] applied_tune;

    // Tune field layout is fixed at four fields per register
    if (rtd_pkg::SEQ_STEPS != 8 || rtd_pkg::TUNE_W * 4 != rtd_pkg::REG_W
        || rtd_pkg::ROLL_SEL_LSB + 3 > rtd_pkg::ROLL_W) begin : g_chk
        $error("rtd_clock_ctrl needs eight 4-bit tune fields and rollover bits 5:3");
    end

    // Pin-level inputs from the oscillator domain
    rtd_sync #(
        .W(2)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({osc_fail_detect, osc_running}),
        .sync_out(sync_out)
    );

    assign osc_fail_s = sync_out[1];
    assign osc_running_s = sync_out[0];

    // Configuration decode
    assign switch_allowed = ~cfg.switch_monitor_config[rtd_pkg::SWITCH_MONITOR_CONFIG_OFF_BIT];
    assign monitor_on = cfg.switch_monitor_config == rtd_pkg::SWITCH_MONITOR_CONFIG_MON_ON;
    assign direct_osc = {1'b0, cfg.new_osc_group_config};
    assign primary_osc = {1'b0, 1'b1, cfg.new_osc_group_config[0]};
    assign target_osc = new_group_primary ? primary_osc : rtd_pkg::OSC_FRC;

    // Primary source lost, or still not running when the power-up timer ends
    assign fail_cause = monitor_on && current_osc_field[rtd_pkg::GRP_BIT]
        && (osc_fail_s || (power_up_timer_expired && !osc_running_s));

    // Wishbone decode
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            rtd_pkg::ADR_OSC_CTRL: begin
                next_rdata[rtd_pkg::CURRENT_OSC_FIELD_LSB +: 3] = current_osc_field;
                next_rdata[rtd_pkg::NGRP_BIT] = new_group_primary;
                next_rdata[rtd_pkg::CF_BIT] = clock_fail_flag;
                next_rdata[rtd_pkg::PSEUDO_RANDOM_DITHER_BIT] = random_dither_enable;
                next_rdata[rtd_pkg::TSEQ_BIT] = tune_sequence_enable;
                next_rdata[rtd_pkg::OSC_SWITCH_ENABLE_BIT] = osc_switch_enable;
            end
            rtd_pkg::ADR_TUNE_A: begin
                next_rdata[15:0] = tune_register_a;
            end
            rtd_pkg::ADR_TUNE_B: begin
                next_rdata[15:0] = tune_register_b;
            end
            rtd_pkg::ADR_STATUS: begin
                next_rdata[3:0] = osc_out.frc_tune;
                next_rdata[rtd_pkg::STAT_LFSR_LSB +: 15] = lfsr_state;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    // Tune registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tune_register_a <= rtd_pkg::TUNE_A_RST;
            tune_register_b <= rtd_pkg::TUNE_B_RST;
        end else if (bus_wr) begin
            if (wb_adr_i == rtd_pkg::ADR_TUNE_A) begin
                tune_register_a <= (tune_register_a & ~wmask) | (wb_dat_i[15:0] & wmask);
            end
            if (wb_adr_i == rtd_pkg::ADR_TUNE_B) begin
                tune_register_b <= (tune_register_b & ~wmask) | (wb_dat_i[15:0] & wmask);
            end
        end
    end

    // Mode bits and group request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            random_dither_enable <= 1'b0;
            tune_sequence_enable <= 1'b0;
            new_group_primary <= 1'b0;
        end else if (bus_wr && wb_adr_i == rtd_pkg::ADR_OSC_CTRL) begin
            if (wb_sel_i[0]) begin
                random_dither_enable <= wb_dat_i[rtd_pkg::PSEUDO_RANDOM_DITHER_BIT];
                tune_sequence_enable <= wb_dat_i[rtd_pkg::TSEQ_BIT];
            end
            if (wb_sel_i[1]) begin
                new_group_primary <= wb_dat_i[rtd_pkg::NGRP_BIT];
            end
        end
    end

    // Clock fail flag, write one to clear, hardware set wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_fail_flag <= 1'b0;
        end else if (state == ST_FAIL_FLAG) begin
            clock_fail_flag <= 1'b1;
        end else if (bus_wr && wb_adr_i == rtd_pkg::ADR_OSC_CTRL && wb_sel_i[0]
                     && wb_dat_i[rtd_pkg::CF_BIT]) begin
            clock_fail_flag <= 1'b0;
        end
    end

    // Switch enable, hardware clear wins over a software write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_switch_enable <= 1'b0;
        end else if (state == ST_FAIL_CLR || state == ST_SWAP || !switch_allowed) begin
            osc_switch_enable <= 1'b0;
        end else if (bus_wr && wb_adr_i == rtd_pkg::ADR_OSC_CTRL && wb_sel_i[0]) begin
            osc_switch_enable <= wb_dat_i[rtd_pkg::OSC_SWITCH_ENABLE_BIT];
        end
    end

    // Switch and failure sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (fail_cause) begin
                    next_state = ST_FAIL_CURRENT_OSC_FIELD;
                end else if (switch_allowed && osc_switch_enable) begin
                    if (target_osc[rtd_pkg::GRP_BIT] == current_osc_field[rtd_pkg::GRP_BIT]) begin
                        next_state = ST_SWAP;
                    end else if (new_group_primary) begin
                        next_state = ST_WAIT;
                    end else begin
                        next_state = ST_SWAP;
                    end
                end
            end
            ST_WAIT: begin
                if (!osc_switch_enable || !switch_allowed) begin
                    next_state = ST_IDLE;
                end else if (osc_running_s) begin
                    next_state = ST_SWAP;
                end
            end
            ST_SWAP: begin
                next_state = ST_IDLE;
            end
            ST_FAIL_CURRENT_OSC_FIELD: begin
                next_state = ST_FAIL_FLAG;
            end
            ST_FAIL_FLAG: begin
                next_state = ST_FAIL_CLR;
            end
            ST_FAIL_CLR: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Current oscillator field, loaded from configuration after reset release
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_done <= 1'b0;
            current_osc_field <= rtd_pkg::OSC_FRC;
        end else begin
            init_done <= 1'b1;
            if (!init_done || !switch_allowed) begin
                current_osc_field <= direct_osc;
            end else if (state == ST_FAIL_CURRENT_OSC_FIELD) begin
                current_osc_field <= rtd_pkg::OSC_FRC;
            end else if (state == ST_SWAP
                         && target_osc[rtd_pkg::GRP_BIT] != current_osc_field[rtd_pkg::GRP_BIT]) begin
                current_osc_field <= target_osc;
            end
        end
    end

    // Trap pulse once the sequence is complete
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_fail_trap <= 1'b0;
        end else begin
            clock_fail_trap <= state == ST_FAIL_CLR;
        end
    end

    // Watchdog clock is kept out of every failure path
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_power_rc_wdt_run <= 1'b0;
        end else begin
            low_power_rc_wdt_run <= 1'b1;
        end
    end

    // Oscillator selection outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_osc <= rtd_pkg::OSC_FRC;
            applied_mode <= 2'h0;
        end else begin
            applied_osc <= switch_allowed ? current_osc_field : direct_osc;
            applied_mode <= cfg.primary_osc_mode_config;
        end
    end

    // Pseudo-random dither steps on every change of rollover bit 3
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            roll3_prev <= 1'b0;
        end else begin
            roll3_prev <= rollover_count[rtd_pkg::ROLL_SEL_LSB];
        end
    end

    assign lfsr_step = random_dither_enable
        && (rollover_count[rtd_pkg::ROLL_SEL_LSB] != roll3_prev);

    rtd_lfsr #(
        .W(rtd_pkg::LFSR_W)
    ) u_lfsr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .step(lfsr_step),
        .state(lfsr_state)
    );

    // Sequence fields: base tune first, then seven sequence values across both registers
    for (genvar i = 0; i < rtd_pkg::SEQ_STEPS; i++) begin : g_seq
        if (i < 4) begin : g_a
            assign seq_field[i] = tune_register_a[i*rtd_pkg::TUNE_W +: rtd_pkg::TUNE_W];
        end else begin : g_b
            assign seq_field[i] = tune_register_b[(i-4)*rtd_pkg::TUNE_W +: rtd_pkg::TUNE_W];
        end
    end

    // Rollover counter bits 5:3 steer the eight-way mux
    assign roll_sel = rollover_count[rtd_pkg::ROLL_SEL_LSB +: 3];

    always_comb begin
        next_tune = seq_field[0];
        if (random_dither_enable) begin
            next_tune = lfsr_state[rtd_pkg::TUNE_W-1:0];
        end else if (tune_sequence_enable) begin
            next_tune = seq_field[roll_sel];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_tune <= 4'h0;
        end else begin
            applied_tune <= next_tune;
        end
    end

    // One driver for the whole output bundle
    assign osc_out = {applied_osc, applied_mode, applied_tune};
endmodule // rtd_clock_ctrl

// File: verilog/rtd_lfsr.sv
// Fifteen-bit Fibonacci shift register for pseudo-random tune dither
`timescale 1ns/1ps
module rtd_lfsr #(
    parameter int W = rtd_pkg::LFSR_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic step,
    output logic [W-1:0] state
);
    logic feedback;

    if (W != rtd_pkg::LFSR_W) begin : g_chk
        $error("rtd_lfsr taps are fixed for fifteen bits");
    end

    assign feedback = state[rtd_pkg::LFSR_TAP_A] ^ state[rtd_pkg::LFSR_TAP_B];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rtd_pkg::LFSR_SEED;
        end else if (step) begin
            state <= {state[W-2:0], feedback};
        end
    end
endmodule // rtd_lfsr

// File: verilog/rtd_pkg.sv
// Package of constants and types for the RC tune dither and fail-safe clock block
// What this block does
// - Sequence mode steps eight tune values, one every eight rollovers
// - Sequence and random dither off: base tune field alone drives tune
// - 4-bit eight-way mux, rollover bits 5:3 select
// - Random dither uses 15-bit XOR-feedback shift register
// - Random mode applies shift register low four bits
// - Random dither only while its enable bit set
// - Shift register steps when rollover bit 3 toggles
// - Monitor on and failure: trap, move to fast RC
// - Clock fail flag, control bit 3, set on failure
// - Watchdog keeps running on low-power RC clock
// - Timer expiry before oscillator runs counts as failure
// - Failure order: load fast RC, set flag, clear enable
// - Switch only between groups, never within one
// - Primary group source picked by group config field
// - Config field 1x disables switching and monitor
// - Switching off: config selects, current field mirrors
// - Tune taken from register a or b by rollover bits 5:3
package rtd_pkg;
    localparam logic [7:0] ADR_OSC_CTRL = 8'h00;
    localparam logic [7:0] ADR_TUNE_A = 8'h04;
    localparam logic [7:0] ADR_TUNE_B = 8'h08;
    localparam logic [7:0] ADR_STATUS = 8'h0C;
    localparam int REG_W = 16;
    localparam int CURRENT_OSC_FIELD_LSB = 12;
    localparam int NGRP_BIT = 8;
    localparam int CF_BIT = 3;
    localparam int PSEUDO_RANDOM_DITHER_BIT = 2;
    localparam int TSEQ_BIT = 1;
    localparam int OSC_SWITCH_ENABLE_BIT = 0;
    localparam int STAT_LFSR_LSB = 4;
    localparam int TUNE_W = 4;
    localparam int SEQ_STEPS = 8;
    localparam int ROLL_W = 6;
    localparam int ROLL_SEL_LSB = 3;
    localparam int LFSR_W = 15;
    localparam int LFSR_TAP_A = 14;
    localparam int LFSR_TAP_B = 13;
    localparam logic [14:0] LFSR_SEED = 15'h0001;
    localparam logic [15:0] TUNE_A_RST = 16'h0000;
    localparam logic [15:0] TUNE_B_RST = 16'h0000;
    localparam logic [2:0] OSC_FRC = 3'h0;
    localparam logic [2:0] OSC_FRC_PLL = 3'h1;
    localparam logic [2:0] OSC_PRI = 3'h2;
    localparam logic [2:0] OSC_PRI_PLL = 3'h3;
    localparam int GRP_BIT = 1;
    localparam int SWITCH_MONITOR_CONFIG_OFF_BIT = 1;
    localparam logic [1:0] SWITCH_MONITOR_CONFIG_MON_ON = 2'h0;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic [1:0] switch_monitor_config;
        logic [1:0] new_osc_group_config;
        logic [1:0] primary_osc_mode_config;
    } rtd_cfg_t;

    typedef struct packed {
        logic [2:0] osc_select;
        logic [1:0] primary_mode;
        logic [3:0] frc_tune;
    } rtd_osc_out_t;
endpackage

// File: verilog/rtd_sync.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module rtd_sync #(
    parameter int W = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage_a;

    if (W < 1) begin : g_chk
        $error("rtd_sync needs W of at least 1");
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_a <= '0;
            sync_out <= '0;
        end else begin
            stage_a <= async_in;
            sync_out <= stage_a;
        end
    end
endmodule // rtd_sync
